// file: hdl/status_pkg.sv
// shared constants and types for the cpu status register block
package status_pkg;

  // ------------------------------------------------------------
  // status bit positions and reset value
  // ------------------------------------------------------------
  localparam int         BIT_CARRY      = 0;
  localparam int         BIT_NIBBLE     = 1;
  localparam int         BIT_ZERO       = 2;
  localparam int         BIT_POWERDOWN  = 3;
  localparam int         BIT_TIMEOUT    = 4;
  localparam int         BIT_BANK       = 5;
  localparam int         BIT_UPPER_RSV  = 6;
  localparam int         BIT_INDIR_RSV  = 7;
  localparam logic [2:0] BANK_BITS_RST  = 3'h0;
  localparam logic       TIMEOUT_RST    = 1'b1;
  localparam logic       POWERDOWN_RST  = 1'b1;
  localparam logic [2:0] ARITH_RST      = 3'h0;

  // ------------------------------------------------------------
  // register map: printed offsets are indices, byte address = 4 * index
  // ------------------------------------------------------------
  localparam int          HADDR_W           = 12;
  localparam logic [7:0]  STATUS_INDEX      = 8'h03;
  localparam logic [7:0]  STATUS_ALIAS_INDEX = 8'h83;
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  localparam logic [2:0]  HSIZE_WORD        = 3'h2;

  // ------------------------------------------------------------
  // instruction operations seen by the flag logic
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR, OP_COM,
    OP_INC, OP_DEC, OP_MOVE, OP_SWAP, OP_BIT_CLR, OP_BIT_SET, OP_ROT_L,
    OP_ROT_R
  } alu_op_e;

  // one executed instruction, from core logic on the same clock
  typedef struct packed {
    logic       valid;
    alu_op_e    op;
    logic [7:0] acc;
    logic [7:0] operand;
    logic [2:0] bit_sel;
    logic       dest_status;
  } exec_s;

  // reset-cause events, one-cycle pulses
  typedef struct packed {
    logic watchdog_clear;
    logic sleep_enter;
    logic watchdog_timeout;
  } cause_s;

  // register write from the bus slave
  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } reg_wr_s;

endpackage

// file: hdl/reset_cause_flags.sv
// time-out and power-down flags, driven only by hardware events
`timescale 1ns/1ns
module reset_cause_flags (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // events
  input  wire status_pkg::cause_s cause,
  // flags
  output logic                   timeout_flag,
  output logic                   powerdown_flag
);

  // power-up is the asynchronous reset; writes never reach these bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_flag <= status_pkg::TIMEOUT_RST;
    end else if (cause.watchdog_timeout) begin
      // a time-out that lands with a sleep or clear is kept, it is the rarer event
      timeout_flag <= 1'b0;
    end else if (cause.watchdog_clear || cause.sleep_enter) begin
      timeout_flag <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powerdown_flag <= status_pkg::POWERDOWN_RST;
    end else if (cause.sleep_enter) begin
      powerdown_flag <= 1'b0;
    end else if (cause.watchdog_clear) begin
      powerdown_flag <= 1'b1;
    end
  end

endmodule // reset_cause_flags

// file: hdl/status_ahb_slave.sv
// ahb-lite slave front end for the status register
`timescale 1ns/1ns
module status_ahb_slave (
  // clock and reset
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  // ahb-lite slave port
  input  wire logic                            hsel,
  input  wire logic [status_pkg::HADDR_W-1:0]  haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic                                 hreadyout,
  output logic                                 hresp,
  output logic [31:0]                          hrdata,
  // register side
  input  wire logic [7:0]                      status_value,
  output status_pkg::reg_wr_s                  status_wr
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic hits_status(input logic [status_pkg::HADDR_W-1:0] a);
    hits_status = (a == {2'h0, status_pkg::STATUS_INDEX, 2'h0})
               || (a == {2'h0, status_pkg::STATUS_ALIAS_INDEX, 2'h0});
  endfunction

  logic take;
  logic hit;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic rd_hit_reg;

  assign take = hsel && hready && htrans[1] && (hsize == status_pkg::HSIZE_WORD);
  assign hit  = hits_status(haddr);

  // ------------------------------------------------------------
  // data phase tracking
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
    end else if (hready) begin
      wr_pend_reg <= take && hwrite && hit;
    end
  end

  // reads take one wait state so that hrdata comes from a flop and sees last write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_reg <= 1'b0;
      rd_hit_reg  <= 1'b0;
    end else if (rd_pend_reg) begin
      rd_pend_reg <= 1'b0;
    end else if (hready) begin
      rd_pend_reg <= take && !hwrite;
      rd_hit_reg  <= hit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_pend_reg) begin
      hrdata <= rd_hit_reg ? {24'h0, status_value} : 32'h0;
    end
  end

  assign hreadyout      = !rd_pend_reg;
  assign hresp          = 1'b0;
  assign status_wr.en   = wr_pend_reg;
  assign status_wr.data = hwdata[7:0];

endmodule // status_ahb_slave

// file: hdl/cpu_status_flag_register.sv
// cpu status register: alu flags, reset-cause flags and bank select
//
// What this block does
// - status register is a normal instruction destination
// - flag-affecting writes take flags from alu
// - time-out and power-down bits ignore writes
// - clear op zeroes upper bits, sets zero
// - bank bit picks upper or lower bank
// - nibble carry from bit 3 on add/sub
// - carry from msb on add/sub
// - subtraction flags are inverted borrows
`timescale 1ns/1ns
module cpu_status_flag_register (
  // clock and reset
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  // ahb-lite slave port
  input  wire logic                            hsel,
  input  wire logic [status_pkg::HADDR_W-1:0]  haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic                                 hreadyout,
  output logic                                 hresp,
  output logic [31:0]                          hrdata,
  // core execution side
  input  wire status_pkg::exec_s               exec,
  input  wire status_pkg::cause_s              cause,
  input  wire logic [6:0]                      direct_offset,
  // results
  output logic [7:0]                           alu_result,
  output logic                                 alu_result_valid,
  output logic [7:0]                           status_byte,
  output logic                                 bank_select,
  output logic [7:0]                           direct_address
);

  // ------------------------------------------------------------
  // arithmetic helpers
  // ------------------------------------------------------------
  function automatic logic [8:0] add_byte(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    add_byte = {1'b0, a} + {1'b0, b} + {8'h0, cin};
  endfunction

  function automatic logic [4:0] add_nibble(input logic [3:0] a, input logic [3:0] b,
                                            input logic cin);
    add_nibble = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [2:0]          bank_bits_reg;
  logic                zero_reg;
  logic                nibble_carry_reg;
  logic                carry_reg;
  logic                timeout_flag;
  logic                powerdown_flag;
  status_pkg::reg_wr_s status_wr;

  // alu outputs
  logic [7:0] res;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic       flag_c;
  logic       flag_dc;
  logic       flag_z;
  logic       aff_z;
  logic       aff_dc;
  logic       aff_c;
  logic [7:0] bit_mask;

  // ------------------------------------------------------------
  // bus front end and reset-cause flags
  // ------------------------------------------------------------
  status_ahb_slave u_slave (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .hrdata       (hrdata),
    .status_value (status_byte),
    .status_wr    (status_wr)
  );

  reset_cause_flags u_cause (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .cause          (cause),
    .timeout_flag   (timeout_flag),
    .powerdown_flag (powerdown_flag)
  );

  // ------------------------------------------------------------
  // alu result and flag outcome
  // ------------------------------------------------------------
  assign bit_mask = 8'h01 << exec.bit_sel;

  always_comb begin
    res     = exec.operand;
    sum9    = 9'h0;
    sum5    = 5'h0;
    flag_c  = carry_reg;
    flag_dc = nibble_carry_reg;
    aff_z   = 1'b0;
    aff_dc  = 1'b0;
    aff_c   = 1'b0;
    case (exec.op)
      status_pkg::OP_ADD: begin
        sum9    = add_byte(exec.operand, exec.acc, 1'b0);
        sum5    = add_nibble(exec.operand[3:0], exec.acc[3:0], 1'b0);
        res     = sum9[7:0];
        flag_c  = sum9[8];
        flag_dc = sum5[4];
        aff_z   = 1'b1;
        aff_dc  = 1'b1;
        aff_c   = 1'b1;
      end
      status_pkg::OP_SUB: begin
        // operand minus acc as operand + ~acc + 1, so carry out means no borrow
        sum9    = add_byte(exec.operand, ~exec.acc, 1'b1);
        sum5    = add_nibble(exec.operand[3:0], ~exec.acc[3:0], 1'b1);
        res     = sum9[7:0];
        flag_c  = sum9[8];
        flag_dc = sum5[4];
        aff_z   = 1'b1;
        aff_dc  = 1'b1;
        aff_c   = 1'b1;
      end
      status_pkg::OP_AND: begin
        res   = exec.operand & exec.acc;
        aff_z = 1'b1;
      end
      status_pkg::OP_IOR: begin
        res   = exec.operand | exec.acc;
        aff_z = 1'b1;
      end
      status_pkg::OP_XOR: begin
        res   = exec.operand ^ exec.acc;
        aff_z = 1'b1;
      end
      status_pkg::OP_CLR: begin
        res   = 8'h00;
        aff_z = 1'b1;
      end
      status_pkg::OP_COM: begin
        res   = ~exec.operand;
        aff_z = 1'b1;
      end
      status_pkg::OP_INC: begin
        sum9  = add_byte(exec.operand, 8'h01, 1'b0);
        res   = sum9[7:0];
        aff_z = 1'b1;
      end
      status_pkg::OP_DEC: begin
        sum9  = add_byte(exec.operand, 8'hFF, 1'b0);
        res   = sum9[7:0];
        aff_z = 1'b1;
      end
      status_pkg::OP_MOVE: begin
        res   = exec.operand;
        aff_z = 1'b1;
      end
      status_pkg::OP_SWAP: begin
        res = {exec.operand[3:0], exec.operand[7:4]};
      end
      status_pkg::OP_BIT_CLR: begin
        res = exec.operand & ~bit_mask;
      end
      status_pkg::OP_BIT_SET: begin
        res = exec.operand | bit_mask;
      end
      status_pkg::OP_ROT_L: begin
        res    = {exec.operand[6:0], carry_reg};
        flag_c = exec.operand[7];
        aff_c  = 1'b1;
      end
      status_pkg::OP_ROT_R: begin
        res    = {carry_reg, exec.operand[7:1]};
        flag_c = exec.operand[0];
        aff_c  = 1'b1;
      end
      status_pkg::OP_NONE: begin
        // plain store of the accumulator into the destination
        res = exec.acc;
      end
      default: begin
        res = exec.operand;
      end
    endcase
  end

  assign flag_z = (res == 8'h00);

  // ------------------------------------------------------------
  // write priority for the status bits
  // ------------------------------------------------------------
  // bank and carry bus paths decided here; the zero process tests status_wr.en itself
  logic instr_to_status;
  logic instr_sets_dc_c;
  logic bus_to_bank;
  logic bus_to_dc_c;

  // the core and software share this register; an instruction result always wins
  assign instr_to_status = exec.valid && exec.dest_status;
  // a clear aimed at the status register leaves both carries alone
  assign instr_sets_dc_c = instr_to_status && (exec.op != status_pkg::OP_CLR);
  assign bus_to_bank     = status_wr.en && !instr_to_status;
  // any instruction in flight may move the carries, so the bus gives way to all of them
  assign bus_to_dc_c     = status_wr.en && !exec.valid;

  // ------------------------------------------------------------
  // bank and reserved bits: written from instruction or bus
  // ------------------------------------------------------------
  // an instruction result wins over a bus write landing in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_bits_reg <= status_pkg::BANK_BITS_RST;
    end else if (instr_to_status) begin
      // the reserved pair is stored as written; software keeps it clear
      bank_bits_reg <= res[status_pkg::BIT_INDIR_RSV:status_pkg::BIT_BANK];
    end else if (bus_to_bank) begin
      bank_bits_reg <= status_wr.data[status_pkg::BIT_INDIR_RSV:status_pkg::BIT_BANK];
    end
  end

  // ------------------------------------------------------------
  // arithmetic flags
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_reg <= status_pkg::ARITH_RST[status_pkg::BIT_ZERO];
    end else if (exec.valid && aff_z) begin
      zero_reg <= flag_z;
    end else if (instr_to_status) begin
      zero_reg <= res[status_pkg::BIT_ZERO];
    end else if (status_wr.en) begin
      zero_reg <= status_wr.data[status_pkg::BIT_ZERO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nibble_carry_reg <= status_pkg::ARITH_RST[status_pkg::BIT_NIBBLE];
    end else if (exec.valid && aff_dc) begin
      nibble_carry_reg <= flag_dc;
    end else if (instr_sets_dc_c) begin
      nibble_carry_reg <= res[status_pkg::BIT_NIBBLE];
    end else if (bus_to_dc_c) begin
      nibble_carry_reg <= status_wr.data[status_pkg::BIT_NIBBLE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_reg <= status_pkg::ARITH_RST[status_pkg::BIT_CARRY];
    end else if (exec.valid && aff_c) begin
      carry_reg <= flag_c;
    end else if (instr_sets_dc_c) begin
      carry_reg <= res[status_pkg::BIT_CARRY];
    end else if (bus_to_dc_c) begin
      carry_reg <= status_wr.data[status_pkg::BIT_CARRY];
    end
  end

  // ------------------------------------------------------------
  // result register for the core
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alu_result       <= 8'h00;
      alu_result_valid <= 1'b0;
    end else begin
      alu_result_valid <= exec.valid;
      if (exec.valid) begin
        alu_result <= res;
      end
    end
  end

  // ------------------------------------------------------------
  // status view and bank addressing
  // ------------------------------------------------------------
  // time-out and power-down come from their own flops, never from a write
  assign status_byte    = {bank_bits_reg, timeout_flag, powerdown_flag,
                           zero_reg, nibble_carry_reg, carry_reg};
  assign bank_select    = bank_bits_reg[0];
  assign direct_address = {bank_select, direct_offset};

endmodule // cpu_status_flag_register

// file: testbench/cpu_status_flag_register_assertions.sv
// concurrent checks on the status register block ports
`timescale 1ns/1ns
module status_checker (
  // clock and reset
  input wire logic                           hclk,
  input wire logic                           hresetn,
  // bus
  input wire logic                           hsel,
  input wire logic [status_pkg::HADDR_W-1:0] haddr,
  input wire logic [1:0]                     htrans,
  input wire logic                           hwrite,
  input wire logic [2:0]                     hsize,
  input wire logic                           hready,
  input wire logic                           hreadyout,
  input wire logic                           hresp,
  // core side and results
  input wire status_pkg::exec_s              exec,
  input wire status_pkg::cause_s             cause,
  input wire logic [6:0]                     direct_offset,
  input wire logic [7:0]                     status_byte,
  input wire logic                           bank_select,
  input wire logic [7:0]                     direct_address
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // reference flags, subtract is operand minus acc
  // ------------------------------------------------------------
  logic [8:0] sum;
  logic [4:0] nib;
  logic [2:0] exp_flags;
  logic [2:0] exp_q;
  always_comb begin
    if (exec.op == status_pkg::OP_SUB) begin
      sum = {1'h0, exec.operand} - {1'h0, exec.acc};
      nib = {1'h0, exec.operand[3:0]} - {1'h0, exec.acc[3:0]};
      exp_flags = {sum[7:0] == 8'h00, ~nib[4], ~sum[8]};
    end else begin
      sum = {1'h0, exec.operand} + {1'h0, exec.acc};
      nib = {1'h0, exec.operand[3:0]} + {1'h0, exec.acc[3:0]};
      exp_flags = {sum[7:0] == 8'h00, nib[4], sum[8]};
    end
  end
  always_ff @(posedge hclk) begin
    exp_q <= exp_flags;
  end

  sequence rd_req;
    hsel && hready && htrans[1] && !hwrite && hsize == status_pkg::HSIZE_WORD;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  bank_route_a: assert property (bank_select == status_byte[5])
    else $error("bank select differs from status bit 5");
  addr_route_a: assert property (direct_address == {bank_select, direct_offset})
    else $error("direct address not built from bank bit");
  read_wait_a: assert property (rd_req |=> rd_wait)
    else $error("read data phase timing wrong");
  okay_resp_a: assert property (hresp == 1'h0)
    else $error("bus response not okay");
  cause_hold_a: assert property (cause == '0 |=> $stable(status_byte[4:3]))
    else $error("reset cause flags changed without event");
  timeout_clr_a: assert property (cause.watchdog_timeout |=> !status_byte[4])
    else $error("time-out flag not cleared");
  sleep_flags_a: assert property (cause.sleep_enter && !cause.watchdog_timeout
    |=> status_byte[4:3] == 2'h2)
    else $error("sleep flags wrong");
  add_flags_a: assert property (exec.valid && exec.op == status_pkg::OP_ADD
    |=> status_byte[2:0] == exp_q)
    else $error("add flags wrong");
  sub_flags_a: assert property (exec.valid && exec.op == status_pkg::OP_SUB
    |=> status_byte[2:0] == exp_q)
    else $error("subtract flags wrong");
  clr_status_a: assert property (exec.valid && exec.op == status_pkg::OP_CLR && exec.dest_status && cause == '0
    |=> status_byte[7:5] == 3'h0 && status_byte[2] && $stable(status_byte[4:3])
    && $stable(status_byte[1:0]))
    else $error("clear of status wrong");
endmodule // status_checker

bind cpu_status_flag_register status_checker status_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .exec(exec), .cause(cause), .direct_offset(direct_offset), .status_byte(status_byte),
  .bank_select(bank_select), .direct_address(direct_address));

// file: testbench/core_model.sv
// behavioural core: issues instructions and reset-cause events
`timescale 1ns/1ns
module core_model (
  // clock
  input  wire logic          hclk,
  // to the block
  output status_pkg::exec_s  exec,
  output status_pkg::cause_s cause
);
  initial begin
    exec = '0;
    cause = '0;
  end

  // one instruction for one cycle; idle fields scrambled so stale data is never trusted
  task automatic run(input status_pkg::alu_op_e op, input logic [7:0] acc, input logic [7:0] opr,
                     input logic [2:0] bs, input logic ds);
    @(posedge hclk);
    exec <= {1'h1, op, acc, opr, bs, ds};
    @(posedge hclk);
    exec <= {1'h0, status_pkg::OP_NONE, ~acc, ~opr, ~bs, ~ds};
  endtask

  task automatic pulse(input status_pkg::cause_s c);
    @(posedge hclk);
    cause <= c;
    @(posedge hclk);
    cause <= '0;
  endtask
endmodule // core_model

// file: testbench/cpu_status_flag_register_tb.sv
// self-checking bench for the cpu status register
`timescale 1ns/1ns
`define chk_eq(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module cpu_status_flag_register_tb;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic               hwrite;
  logic               hreadyout;
  logic               hresp;
  logic               alu_result_valid;
  logic               bank_select;
  logic [11:0]        haddr;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic [31:0]        rd;
  logic [6:0]         direct_offset;
  logic [7:0]         alu_result;
  logic [7:0]         status_byte;
  logic [7:0]         direct_address;
  logic [30:0]        t;
  status_pkg::exec_s  exec;
  status_pkg::cause_s cause;
  int                 n_fail;
  int                 samples_checked;
  int                 cycles;

  cpu_status_flag_register cpu_status_flag_register_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .exec(exec), .cause(cause),
    .direct_offset(direct_offset), .alu_result(alu_result), .alu_result_valid(alu_result_valid),
    .status_byte(status_byte), .bank_select(bank_select), .direct_address(direct_address));
  core_model core_model_i (.hclk(hclk), .exec(exec), .cause(cause));

  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // long enough for every test several times over
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      print_verdict;
    end
  end

  // single ahb-lite word transfer; hready is judged at the rising edge, as the slave sees it
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= status_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= status_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  // op, acc, operand, result, {zero, nibble carry, carry}
  logic [30:0] tab [17] = '{{4'h1, 8'h0F, 8'h01, 8'h10, 3'h2}, {4'h1, 8'hFF, 8'h01, 8'h00, 3'h7},
    {4'h1, 8'h80, 8'h80, 8'h00, 3'h5}, {4'h2, 8'h05, 8'h05, 8'h00, 3'h7}, {4'h2, 8'h01, 8'h10, 8'h0F, 3'h1},
    {4'h2, 8'h01, 8'h00, 8'hFF, 3'h0}, {4'h3, 8'hF0, 8'h0F, 8'h00, 3'h4}, {4'hE, 8'h00, 8'h81, 8'h02, 3'h5},
    {4'hF, 8'h00, 8'h02, 8'h81, 3'h4}, {4'hB, 8'h00, 8'hA5, 8'h5A, 3'h4}, {4'h4, 8'h01, 8'h00, 8'h01, 3'h0},
    {4'h8, 8'h00, 8'hFF, 8'h00, 3'h4}, {4'h9, 8'h00, 8'h00, 8'hFF, 3'h0}, {4'h7, 8'h00, 8'hFF, 8'h00, 3'h4},
    {4'h0, 8'h5A, 8'h00, 8'h5A, 3'h4}, {4'hA, 8'h00, 8'h33, 8'h33, 3'h0}, {4'h5, 8'h3C, 8'h3C, 8'h00, 3'h4}};

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    direct_offset = 7'h2A;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(negedge hclk);
    `chk_eq("reset status", 8'h18, status_byte)
    xfer(12'h00C, 1'h0, 32'h0);
    `chk_eq("read status", 32'h18, rd)
    xfer(12'h010, 1'h0, 32'h0);
    `chk_eq("read unmapped", 32'h0, rd)
    $display("test reset and read done");
    xfer(12'h00C, 1'h1, 32'h27);
    xfer(12'h20C, 1'h0, 32'h0);
    `chk_eq("write keeps cause bits", 32'h3F, rd)
    `chk_eq("upper bank address", 8'hAA, direct_address)
    xfer(12'h00C, 1'h1, 32'h0);
    @(negedge hclk);
    `chk_eq("lower bank address", 8'h2A, direct_address)
    $display("test bus write done");
    foreach (tab[i]) begin
      t = tab[i];
      core_model_i.run(status_pkg::alu_op_e'(t[30:27]), t[26:19], t[18:11], 3'h0, 1'h0);
      @(negedge hclk);
      `chk_eq("alu result", t[10:3], alu_result)
      `chk_eq("result valid", 1'h1, alu_result_valid)
      `chk_eq("alu flags", t[2:0], status_byte[2:0])
    end
    $display("test alu flags done");
    core_model_i.run(status_pkg::OP_ADD, 8'h21, 8'hFF, 3'h0, 1'h1);
    @(negedge hclk);
    `chk_eq("add into status", 8'h3B, status_byte)
    core_model_i.run(status_pkg::OP_CLR, 8'h00, 8'h00, 3'h0, 1'h1);
    @(negedge hclk);
    `chk_eq("clear status", 8'h1F, status_byte)
    core_model_i.run(status_pkg::OP_BIT_SET, 8'h00, 8'h1F, 3'h5, 1'h1);
    @(negedge hclk);
    `chk_eq("bit set status", 8'h3F, status_byte)
    `chk_eq("bank select", 1'h1, bank_select)
    core_model_i.run(status_pkg::OP_BIT_CLR, 8'h00, 8'h3F, 3'h5, 1'h1);
    @(negedge hclk);
    `chk_eq("bit clear status", 8'h1F, status_byte)
    $display("test status destination done");
    core_model_i.pulse(status_pkg::cause_s'(3'h2));
    @(negedge hclk);
    `chk_eq("after sleep", 8'h17, status_byte)
    core_model_i.pulse(status_pkg::cause_s'(3'h1));
    @(negedge hclk);
    `chk_eq("after timeout", 8'h07, status_byte)
    xfer(12'h00C, 1'h1, 32'h18);
    @(negedge hclk);
    `chk_eq("cause bits locked", 8'h00, status_byte)
    core_model_i.pulse(status_pkg::cause_s'(3'h5));
    @(negedge hclk);
    `chk_eq("timeout beats clear", 8'h08, status_byte)
    core_model_i.pulse(status_pkg::cause_s'(3'h4));
    @(negedge hclk);
    `chk_eq("after watchdog clear", 8'h18, status_byte)
    $display("test reset cause done");
    print_verdict;
  end
endmodule // cpu_status_flag_register_tb
